// ---- design/ats_sequencer.sv ----
// Purpose: Register file, conversion control and touch sequencer of the converter
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: The analog front end sits outside; it returns convValue at conversion end
//
// Overview of operation
// [RL1] A conversion samples four converter clocks then converts for twelve.
// [RL2] Back-to-back conversions get one extra converter clock between them.
// [RL3] Converter clock is the system clock divided by the programmed factor.
// [RL4] Start bit launches on one, reads one while busy, self-clears, zero stops.
// [RL5] End status reads one after completion, zero while converting.
// [RL6] The twelve-bit result is placed in the result register on completion.
// [RL7] Differential channel 0 is input0 minus input2, channel 1 input1 minus input3.
// [RL8] Differential results are coded around 0x800 midpoint.
// [RL9] Channel fifteen routes the powered temperature sensor to the converter.
// [RL10] Software discards the first result after configuring a channel.
// [RL11] Touch control and conversion control are one register at two addresses.
// [RL12] Activity bit covers charge, discharge and conversion; charging bit only charge.
// [RL13] Touch enable bit powers the touch module.
// [RL14] Write-only charge count gives charge time in system clocks, at least sixteen.
// [RL15] Discharge lasts eight clocks below count 128, fourteen from 128 up.
// [RL16] Software rounds charge counts up to sixteen and 110..127 to 128.
// [RL17] Software sets single-ended, buffer on and 0dB or -6dB before touch.
// [RL18] A write to the touch control register clears the completion flag.
// [RL19] Writing the charge count starts charge, discharge, then conversion.
// [RL20] Service routine reads result, clears flag, selects channel, starts detection.
// [RL21] Completion flag sets at conversion end and stays until a control write.
// [RL22] Converter power enable one turns the converter on, zero off.
// [RL23] Result register holds the last completed value until the next one.
//
// The implementer's own choice: strobed register access.
`default_nettype none
`include "ats_params.svh"
module ats_sequencer #(
  parameter int DIV_W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire ats_pkg::ats_sample_t convValue,
  output logic convPowerEnable,
  output logic inputBufferEnable,
  output logic [1:0] ampGainSelect,
  output logic differentialEnable,
  output ats_pkg::ats_channel_t muxPositive,
  output ats_pkg::ats_channel_t muxNegative,
  output logic tempSensorPower,
  output logic tempSensorRoute,
  output logic touchModuleEnable,
  output logic touchChargeDrive,
  output logic touchDischargeDrive,
  output logic sampleHold,
  output logic convertPhase
);
  import ats_pkg::*;

  ats_conv_if conv ();

  logic [7:0] configReg;
  ats_channel_t channelSelect;
  logic [7:0] tempReg;
  logic touchEnable;
  logic endStatus;
  logic irqFlag;
  ats_sample_t result;
  ats_touch_state_t touchState;
  logic [7:0] touchCount;
  logic [7:0] chargeCount;
  logic ctrlWrite;
  logic countWrite;
  logic startWrite;
  logic stopWrite;
  logic touchLaunch;
  logic powerOn;
  logic diffMode;
  logic [DIV_W-1:0] divFactor;
  logic [7:0] ctrlValue;
  logic [15:0] next_rdata;

  // Address decode of the write strobe
  assign ctrlWrite = regWrite &&
                     (regAddr == `ATS_ADDR_CONV_CTRL || regAddr == `ATS_ADDR_TOUCH_CTRL); // [RL11]
  assign countWrite = regWrite && (regAddr == `ATS_ADDR_CHARGE_CNT);
  assign powerOn = configReg[`ATS_CFG_POWER_BIT];
  assign diffMode = configReg[`ATS_CFG_DIFF_BIT];
  assign startWrite = ctrlWrite && regWdata[`ATS_CTRL_START_BIT] && powerOn;
  assign stopWrite = ctrlWrite && !regWdata[`ATS_CTRL_START_BIT];
  assign touchLaunch = countWrite && touchEnable && powerOn && (touchState == TK_IDLE);

  // Requests to the conversion timer
  assign conv.startReq = (startWrite && touchState == TK_IDLE) || // [RL4]
                         (touchState == TK_DISCHARGE && touchCount <= 8'h01); // [RL19]
  assign conv.stopReq = stopWrite || !powerOn; // [RL4] [RL22]

  // Converter clock is the system clock divided by factor code plus one
  assign divFactor = DIV_W'(configReg[7:`ATS_CFG_DIV_LSB]) + DIV_W'(1); // [RL3]

  ats_clk_div #(
    .W(DIV_W)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(powerOn),
    .factor(divFactor),
    .tick(conv.tick)
  );

  ats_conv_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .conv(conv)
  );

  // Configuration, channel and temperature sensor registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      configReg <= `ATS_RST_CONFIG;
      channelSelect <= `ATS_RST_CHANNEL;
      tempReg <= `ATS_RST_TEMP;
    end else if (regWrite) begin
      if (regAddr == `ATS_ADDR_CONFIG) begin
        configReg <= regWdata[7:0]; // [RL22]
      end else if (regAddr == `ATS_ADDR_CHANNEL) begin
        channelSelect <= regWdata[3:0];
      end else if (regAddr == `ATS_ADDR_TEMP) begin
        tempReg <= regWdata[7:0];
      end
    end
  end

  // Touch enable bit lives in the shared control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      touchEnable <= 1'b0;
    end else if (ctrlWrite) begin
      touchEnable <= regWdata[`ATS_CTRL_TOUCH_EN_BIT]; // [RL13] [RL11]
    end
  end

  // Completion flag: set wins over the clearing control write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqFlag <= 1'b0;
    end else if (conv.done) begin
      irqFlag <= 1'b1; // [RL21]
    end else if (ctrlWrite) begin
      irqFlag <= 1'b0; // [RL18] [RL21]
    end
  end

  // End status: low from launch until completion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      endStatus <= 1'b0;
    end else if (conv.done) begin
      endStatus <= 1'b1; // [RL5]
    end else if (conv.startReq) begin
      endStatus <= 1'b0; // [RL5]
    end
  end

  // Result capture, midpoint coding for differential mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result <= '0;
    end else if (conv.done) begin
      if (diffMode) begin
        result <= convValue + `ATS_MIDPOINT; // [RL8] [RL6]
      end else begin
        result <= convValue; // [RL6]
      end
    end
  end // Held otherwise [RL23]

  // Write-only charge count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chargeCount <= `ATS_RST_COUNT;
    end else if (countWrite) begin
      chargeCount <= regWdata[7:0]; // [RL14]
    end
  end

  // Touch sequence: charge, discharge, then a conversion
  always_ff @(posedge core_clk) begin
    if (!rst_n || stopWrite || !powerOn || !touchEnable) begin
      touchState <= TK_IDLE;
      touchCount <= '0;
    end else begin
      case (touchState)
        TK_IDLE: begin
          if (touchLaunch) begin
            touchState <= TK_CHARGE; // [RL19]
            touchCount <= regWdata[7:0]; // [RL14]
          end
        end
        TK_CHARGE: begin
          if (touchCount <= 8'h01) begin
            touchState <= TK_DISCHARGE;
            if (chargeCount < `ATS_CHARGE_LIMIT) begin
              touchCount <= `ATS_DISCH_SHORT; // [RL15]
            end else begin
              touchCount <= `ATS_DISCH_LONG; // [RL15]
            end
          end else begin
            touchCount <= touchCount - 8'h01;
          end
        end
        TK_DISCHARGE: begin
          if (touchCount <= 8'h01) begin
            touchState <= TK_CONVERT; // [RL19]
            touchCount <= '0;
          end else begin
            touchCount <= touchCount - 8'h01;
          end
        end
        default: begin
          if (conv.done) begin
            touchState <= TK_IDLE;
          end
        end
      endcase
    end
  end

  // Shared control register image
  always_comb begin
    ctrlValue = 8'h00;
    ctrlValue[`ATS_CTRL_START_BIT] = conv.busy; // [RL4]
    ctrlValue[`ATS_CTRL_TOUCH_EN_BIT] = touchEnable;
    ctrlValue[`ATS_CTRL_TOUCH_ACT_BIT] = (touchState != TK_IDLE); // [RL12]
    ctrlValue[`ATS_CTRL_CHARGING_BIT] = (touchState == TK_CHARGE); // [RL12]
    ctrlValue[`ATS_CTRL_EOC_BIT] = endStatus; // [RL5]
  end

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (regAddr == `ATS_ADDR_CONV_CTRL || regAddr == `ATS_ADDR_TOUCH_CTRL) begin
      next_rdata = {8'h00, ctrlValue}; // [RL11]
    end else if (regAddr == `ATS_ADDR_CONFIG) begin
      next_rdata = {8'h00, configReg};
    end else if (regAddr == `ATS_ADDR_CHANNEL) begin
      next_rdata = {12'h000, channelSelect};
    end else if (regAddr == `ATS_ADDR_TEMP) begin
      next_rdata = {8'h00, tempReg};
    end else if (regAddr == `ATS_ADDR_RESULT) begin
      next_rdata = {4'h0, result}; // [RL6]
    end else if (regAddr == `ATS_ADDR_IRQ_FLAG) begin
      next_rdata = {8'h00, irqFlag, 7'h00};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n || !regRead) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= next_rdata;
    end
  end

  // Analog front end controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      convPowerEnable <= 1'b0;
      inputBufferEnable <= 1'b0;
      ampGainSelect <= 2'b00;
      differentialEnable <= 1'b0;
      tempSensorPower <= 1'b0;
      touchModuleEnable <= 1'b0;
    end else begin
      convPowerEnable <= powerOn; // [RL22]
      inputBufferEnable <= configReg[`ATS_CFG_BUFFER_BIT];
      ampGainSelect <= configReg[`ATS_CFG_GAIN_LSB +: 2];
      differentialEnable <= diffMode;
      tempSensorPower <= tempReg[`ATS_TEMP_POWER_BIT];
      touchModuleEnable <= touchEnable; // [RL13]
    end
  end

  // Input multiplexer selection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      muxPositive <= 4'h0;
      muxNegative <= 4'h0;
      tempSensorRoute <= 1'b0;
    end else begin
      muxPositive <= channelSelect;
      muxNegative <= 4'h0;
      if (diffMode && channelSelect == 4'h0) begin
        muxNegative <= 4'h2; // [RL7]
      end else if (diffMode && channelSelect == 4'h1) begin
        muxNegative <= 4'h3; // [RL7]
      end
      tempSensorRoute <= (channelSelect == `ATS_TEMP_CHANNEL) &&
                         tempReg[`ATS_TEMP_POWER_BIT]; // [RL9]
    end
  end

  // Phase drives to the front end and the touch electrode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sampleHold <= 1'b0;
      convertPhase <= 1'b0;
      touchChargeDrive <= 1'b0;
      touchDischargeDrive <= 1'b0;
    end else begin
      sampleHold <= conv.sampling; // [RL1]
      convertPhase <= conv.converting; // [RL1]
      touchChargeDrive <= (touchState == TK_CHARGE);
      touchDischargeDrive <= (touchState == TK_DISCHARGE);
    end
  end
endmodule
`default_nettype wire

// ---- design/ats_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: Included by the sequencer, the conversion timer, the checks and the bench by bare name
// Notes: Definitions only
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

// Register addresses
`define ATS_ADDR_CHANNEL 32'h40001058
`define ATS_ADDR_CONFIG 32'h40001059
`define ATS_ADDR_TOUCH_CTRL 32'h4000105a
`define ATS_ADDR_CONV_CTRL 32'h4000105b
`define ATS_ADDR_RESULT 32'h4000105c
`define ATS_ADDR_TEMP 32'h4000105d
`define ATS_ADDR_IRQ_FLAG 32'h4000105e
`define ATS_ADDR_CHARGE_CNT 32'h4000105f

// Control register fields
`define ATS_CTRL_START_BIT 0
`define ATS_CTRL_TOUCH_EN_BIT 3
`define ATS_CTRL_TOUCH_ACT_BIT 4
`define ATS_CTRL_CHARGING_BIT 5
`define ATS_CTRL_EOC_BIT 7

// Configuration register fields
`define ATS_CFG_POWER_BIT 0
`define ATS_CFG_BUFFER_BIT 1
`define ATS_CFG_DIFF_BIT 2
`define ATS_CFG_GAIN_LSB 4
`define ATS_CFG_DIV_LSB 6

// Other fields
`define ATS_TEMP_POWER_BIT 7
`define ATS_IRQ_FLAG_BIT 7

// Reset values
`define ATS_RST_CONFIG 8'h80
`define ATS_RST_CHANNEL 4'h0
`define ATS_RST_TEMP 8'h04
`define ATS_RST_COUNT 8'h00

// Conversion timing in converter clocks
`define ATS_SAMPLE_TICKS 4'h4
`define ATS_CONVERT_TICKS 4'hc
`define ATS_GAP_TICKS 4'h1

// Touch timing in system clocks
`define ATS_DISCH_SHORT 8'h08
`define ATS_DISCH_LONG 8'h0e
`define ATS_CHARGE_LIMIT 8'h80

// Data coding
`define ATS_MIDPOINT 12'h800
`define ATS_TEMP_CHANNEL 4'hf

`endif

// ---- design/ats_pkg.sv ----
// Purpose: Types shared by the sequencer modules
// Assumes: Constants live in ats_params.svh
// Notes: Types only
`default_nettype none
package ats_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SAMPLE = 2'b01,
    CONV_CONVERT = 2'b10,
    CONV_GAP = 2'b11
  } ats_conv_state_t;

  typedef enum logic [1:0] {
    TK_IDLE = 2'b00,
    TK_CHARGE = 2'b01,
    TK_DISCHARGE = 2'b10,
    TK_CONVERT = 2'b11
  } ats_touch_state_t;

  typedef logic [11:0] ats_sample_t;
  typedef logic [3:0] ats_channel_t;
endpackage
`default_nettype wire

// ---- design/ats_conv_if.sv ----
// Purpose: Handshake between the register side and the conversion timer
// Assumes: All signals in the core_clk domain
// Notes: Start requests are one-cycle pulses; the stop request also stays high while power is off
`default_nettype none
interface ats_conv_if;
  logic tick;
  logic startReq;
  logic stopReq;
  logic busy;
  logic sampling;
  logic converting;
  logic done;

  modport ctl (output tick, output startReq, output stopReq,
               input busy, input sampling, input converting, input done);
  modport core (input tick, input startReq, input stopReq,
                output busy, output sampling, output converting, output done);
endinterface
`default_nettype wire

// ---- design/ats_clk_div.sv ----
// Purpose: Converter clock enable from the system clock
// Assumes: Divide factor is held stable while enabled
// Notes: Tick is a one-cycle pulse every factor cycles
`default_nettype none
module ats_clk_div #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [W-1:0] factor,
  output logic tick
);
  logic [W-1:0] count;

  // Free count that restarts whenever the converter is off
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= factor - W'(1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- design/ats_conv_timer.sv ----
// Purpose: Sample, convert and gap phases of one conversion
// Assumes: Tick is the converter clock enable
// Notes: A start during the gap waits for the gap to end
`default_nettype none
`include "ats_params.svh"
module ats_conv_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  ats_conv_if.core conv
);
  import ats_pkg::*;

  ats_conv_state_t state;
  logic [3:0] phaseCount;
  logic pending;

  // Start requests are held until the sequencer can take them
  always_ff @(posedge core_clk) begin
    if (!rst_n || conv.stopReq) begin
      pending <= 1'b0;
    end else if (conv.startReq) begin
      pending <= 1'b1;
    end else if (state == CONV_IDLE) begin
      pending <= 1'b0;
    end
  end

  // Phase sequencer counted in converter clocks
  always_ff @(posedge core_clk) begin
    if (!rst_n || conv.stopReq) begin
      state <= CONV_IDLE;
      phaseCount <= '0;
    end else begin
      case (state)
        CONV_IDLE: begin
          phaseCount <= '0;
          if (pending) begin
            state <= CONV_SAMPLE;
          end
        end
        CONV_SAMPLE: begin
          if (conv.tick) begin
            if (phaseCount == `ATS_SAMPLE_TICKS - 4'h1) begin // [RL1]
              state <= CONV_CONVERT;
              phaseCount <= '0;
            end else begin
              phaseCount <= phaseCount + 4'h1;
            end
          end
        end
        CONV_CONVERT: begin
          if (conv.tick) begin
            if (phaseCount == `ATS_CONVERT_TICKS - 4'h1) begin // [RL1]
              state <= CONV_GAP;
              phaseCount <= '0;
            end else begin
              phaseCount <= phaseCount + 4'h1;
            end
          end
        end
        default: begin
          if (conv.tick) begin
            if (phaseCount == `ATS_GAP_TICKS - 4'h1) begin // [RL2]
              state <= CONV_IDLE;
              phaseCount <= '0;
            end else begin
              phaseCount <= phaseCount + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Phase flags and the completion pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n || conv.stopReq) begin
      conv.done <= 1'b0;
    end else begin
      conv.done <= (state == CONV_CONVERT) && conv.tick &&
                   (phaseCount == `ATS_CONVERT_TICKS - 4'h1);
    end
  end

  assign conv.sampling = (state == CONV_SAMPLE);
  assign conv.converting = (state == CONV_CONVERT);
  assign conv.busy = pending || (state == CONV_SAMPLE) || (state == CONV_CONVERT);
endmodule
`default_nettype wire

// ---- tb/ats_seq_asserts.sv ----
// Purpose: Port-level timing and mapping checks for the sequencer
// Assumes: Bound to ats_sequencer, one clock domain
// Notes: Aborting writes excuse short sample and convert runs
`default_nettype none
`include "ats_params.svh"
module ats_seq_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic convPowerEnable,
  input wire logic inputBufferEnable,
  input wire logic [1:0] ampGainSelect,
  input wire logic differentialEnable,
  input wire ats_pkg::ats_channel_t muxPositive,
  input wire ats_pkg::ats_channel_t muxNegative,
  input wire logic tempSensorPower,
  input wire logic tempSensorRoute,
  input wire logic touchModuleEnable,
  input wire logic touchChargeDrive,
  input wire logic touchDischargeDrive,
  input wire logic sampleHold,
  input wire logic convertPhase
);
  import ats_pkg::*;
  logic ctlAddr;
  logic wrStop;
  // A write that is allowed to cut a conversion short
  assign ctlAddr = regAddr == `ATS_ADDR_CONV_CTRL || regAddr == `ATS_ADDR_TOUCH_CTRL;
  assign wrStop = regWrite && !regWdata[0] && (ctlAddr || regAddr == `ATS_ADDR_CONFIG);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read data only follows a read strobe
  property p_rd_quiet; regRdata != 16'h0000 |-> $past(regRead); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data without strobe");
  // Configuration fields land on the outputs two cycles after the write
  property p_cfg_write;
    regWrite && regAddr == `ATS_ADDR_CONFIG |-> ##2 convPowerEnable == $past(regWdata[0], 2)
      && inputBufferEnable == $past(regWdata[1], 2) && differentialEnable == $past(regWdata[2], 2)
      && ampGainSelect == $past(regWdata[5:4], 2);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config outputs wrong");
  // Sampling lasts at least four cycles unless stopped
  property p_sample_len; $rose(sampleHold) |-> sampleHold[*4] or ##[1:4] wrStop; endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample phase short");
  // Converting lasts at least eight cycles unless stopped
  property p_conv_len; $rose(convertPhase) |-> convertPhase[*8] or ##[1:8] wrStop; endproperty
  a_conv_len: assert property (p_conv_len) else $error("convert phase short");
  // Convert follows sampling; a queued start waits out the gap
  property p_conv_order; $rose(convertPhase) |-> $past(sampleHold); endproperty
  a_conv_order: assert property (p_conv_order) else $error("convert without sample");
  property p_gap; $fell(convertPhase) |-> !sampleHold[*2]; endproperty
  a_gap: assert property (p_gap) else $error("gap missing");
  // Discharge follows charge directly
  property p_disch_order; $rose(touchDischargeDrive) |-> $past(touchChargeDrive); endproperty
  a_disch_order: assert property (p_disch_order) else $error("discharge w/o charge");
  // Differential pairing of the negative mux
  property p_diff0; differentialEnable && muxPositive == 4'h0 |-> muxNegative == 4'h2; endproperty
  a_diff0: assert property (p_diff0) else $error("diff pair 0 wrong");
  property p_diff1; differentialEnable && muxPositive == 4'h1 |-> muxNegative == 4'h3; endproperty
  a_diff1: assert property (p_diff1) else $error("diff pair 1 wrong");
  // Sensor routing needs channel fifteen and sensor power
  property p_temp; tempSensorRoute |-> muxPositive == 4'hf && tempSensorPower; endproperty
  a_temp: assert property (p_temp) else $error("sensor routed wrongly");
  // Powered-down converter stays quiet
  property p_off; !convPowerEnable[*3] |-> !sampleHold && !convertPhase; endproperty
  a_off: assert property (p_off) else $error("activity while unpowered");
  // Charging only with the touch module enabled
  property p_chg_en;
    touchChargeDrive |-> touchModuleEnable || $past(touchModuleEnable);
  endproperty
  a_chg_en: assert property (p_chg_en) else $error("charge while touch off");
endmodule
bind ats_sequencer ats_seq_asserts u_chk (.core_clk, .rst_n, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .convPowerEnable, .inputBufferEnable, .ampGainSelect,
  .differentialEnable, .muxPositive, .muxNegative, .tempSensorPower, .tempSensorRoute,
  .touchModuleEnable, .touchChargeDrive, .touchDischargeDrive, .sampleHold, .convertPhase);
`default_nettype wire

// ---- tb/ats_front_model.sv ----
// Purpose: Analog front end seen by the sequencer
// Assumes: Inputs 0..3 and the sensor level are set by the bench
// Notes: Value is frozen at the end of sampling, like a hold capacitor
`default_nettype none
module ats_front_model (
  input wire logic core_clk,
  input wire ats_pkg::ats_channel_t muxPositive,
  input wire ats_pkg::ats_channel_t muxNegative,
  input wire logic differentialEnable,
  input wire logic tempSensorRoute,
  input wire logic sampleHold,
  input wire ats_pkg::ats_sample_t ain [4],
  input wire ats_pkg::ats_sample_t tempLevel,
  output ats_pkg::ats_sample_t convValue
);
  import ats_pkg::*;
  ats_sample_t held;
  // Track the selected source while sampling
  always_ff @(posedge core_clk) begin
    if (sampleHold) begin
      if (tempSensorRoute) begin
        held <= tempLevel;
      end else if (differentialEnable) begin
        held <= ain[muxPositive[1:0]] - ain[muxNegative[1:0]];
      end else begin
        held <= ain[muxPositive[1:0]];
      end
    end
  end
  assign convValue = held;
endmodule
`default_nettype wire

// ---- tb/ats_sequencer_bench.sv ----
// Purpose: Self-checking bench for the converter and touch sequencer
// Assumes: Read data one cycle after the strobe, 50 MHz clock
// Notes: Reads queue their expected value; a monitor pops and compares
`default_nettype none
`include "ats_params.svh"
module ats_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ats_pkg::*;
  logic core_clk, rst_n, regWrite, regRead, rdLag, lenOn, convPowerEnable, inputBufferEnable;
  logic differentialEnable, tempSensorPower, tempSensorRoute, touchModuleEnable, sampleHold;
  logic touchChargeDrive, touchDischargeDrive, convertPhase;
  logic [31:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [1:0] ampGainSelect, divCode;
  ats_channel_t muxPositive, muxNegative;
  ats_sample_t convValue, tempLevel;
  ats_sample_t ain [4];
  logic [15:0] expQ [$];
  logic [7:0] cnts [3] = '{8'h10, 8'h7f, 8'h80};
  int miscompares = 0;
  int nCompared = 0;
  int seed = 32'hb895;
  int cvLen = 0, shLen = 0, chLen = 0, dsLen = 0, chgN = 16;
  ats_sequencer u_dut (.core_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .convValue, .convPowerEnable, .inputBufferEnable, .ampGainSelect,
    .differentialEnable, .muxPositive, .muxNegative, .tempSensorPower, .tempSensorRoute,
    .touchModuleEnable, .touchChargeDrive, .touchDischargeDrive, .sampleHold, .convertPhase);
  ats_front_model u_front (.core_clk, .muxPositive, .muxNegative, .differentialEnable,
    .tempSensorRoute, .sampleHold, .ain, .tempLevel, .convValue);
  // System clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [15:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
  endtask
  // Count a run of a high output and check its length when it ends
  task runlen(input logic s, inout int n, input int e);
    if (s) n++;
    else if (n != 0) begin
      chk(16'(n), 16'(e));
      n = 0;
    end
  endtask
  // One conversion on a channel, then status, flag and result
  task conv(input ats_channel_t ch, input ats_sample_t e);
    wr(`ATS_ADDR_CHANNEL, {12'h000, ch});
    wr(`ATS_ADDR_CONV_CTRL, 16'h0001);
    rd(`ATS_ADDR_CONV_CTRL, 16'h0001);
    waitc(20 * (divCode + 1) + 10);
    rd(`ATS_ADDR_TOUCH_CTRL, 16'h0080);
    rd(`ATS_ADDR_IRQ_FLAG, 16'h0080);
    rd(`ATS_ADDR_RESULT, {4'h0, e});
  endtask
  // Read results arrive one cycle after the strobe
  always @(posedge core_clk) begin
    rdLag <= regRead;
    if (rdLag) chk(regRdata, expQ.pop_front());
  end
  // Phase length monitor
  always @(posedge core_clk) begin
    if (lenOn) begin
      runlen(convertPhase, cvLen, 12 * (divCode + 1));
      if (divCode == 2'h0) runlen(sampleHold, shLen, 4);
      runlen(touchChargeDrive, chLen, chgN);
      runlen(touchDischargeDrive, dsLen, (chgN < 128) ? 8 : 14);
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    regAddr = 32'h0;
    regWdata = 16'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    rdLag = 1'b0;
    lenOn = 1'b1;
    divCode = 2'h0;
    for (int i = 0; i < 4; i++) ain[i] = 12'($random(seed));
    tempLevel = 12'($random(seed));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`ATS_ADDR_CONFIG, 16'h0080);
    rd(`ATS_ADDR_TEMP, 16'h0004);
    rd(`ATS_ADDR_CHANNEL, 16'h0000);
    rd(`ATS_ADDR_TOUCH_CTRL, 16'h0000);
    rd(`ATS_ADDR_RESULT, 16'h0000);
    rd(`ATS_ADDR_IRQ_FLAG, 16'h0000);
    rd(`ATS_ADDR_CHARGE_CNT, 16'h0000);
    rd(32'h40001060, 16'h0000);
    $display("reset values done");
    for (int c = 0; c < 2; c++) begin
      divCode = 2'(c);
      wr(`ATS_ADDR_CONFIG, {8'h00, divCode, 6'h23});
      conv(ats_channel_t'(c + 1), ain[c + 1]);
    end
    $display("single-ended done");
    divCode = 2'h0;
    wr(`ATS_ADDR_CONFIG, 16'h0025);
    for (int c = 0; c < 2; c++) conv(ats_channel_t'(c), ain[c] - ain[c + 2] + 12'h800);
    $display("differential done");
    wr(`ATS_ADDR_CONFIG, 16'h0023);
    wr(`ATS_ADDR_TEMP, 16'h0084);
    rd(`ATS_ADDR_TEMP, 16'h0084);
    repeat (2) conv(4'hf, tempLevel);
    $display("temperature done");
    wr(`ATS_ADDR_TOUCH_CTRL, 16'h0008);
    rd(`ATS_ADDR_CONV_CTRL, 16'h0088);
    rd(`ATS_ADDR_IRQ_FLAG, 16'h0000);
    foreach (cnts[i]) begin
      chgN = cnts[i];
      wr(`ATS_ADDR_CHANNEL, 16'h0002);
      wr(`ATS_ADDR_CHARGE_CNT, {8'h00, cnts[i]});
      waitc(chgN + 60);
      rd(`ATS_ADDR_TOUCH_CTRL, 16'h0088);
      rd(`ATS_ADDR_RESULT, {4'h0, ain[2]});
      rd(`ATS_ADDR_IRQ_FLAG, 16'h0080);
      wr(`ATS_ADDR_TOUCH_CTRL, 16'h0008);
      rd(`ATS_ADDR_IRQ_FLAG, 16'h0000);
    end
    $display("touch done");
    lenOn = 1'b0;
    wr(`ATS_ADDR_TOUCH_CTRL, 16'h0000);
    wr(`ATS_ADDR_CHANNEL, 16'h0003);
    wr(`ATS_ADDR_CONV_CTRL, 16'h0001);
    wr(`ATS_ADDR_CONV_CTRL, 16'h0001);
    waitc(24);
    wr(`ATS_ADDR_CONV_CTRL, 16'h0000);
    waitc(40);
    rd(`ATS_ADDR_IRQ_FLAG, 16'h0000);
    rd(`ATS_ADDR_RESULT, {4'h0, ain[3]});
    waitc(4);
    $display("stop done");
    print_verdict();
  end
endmodule
`default_nettype wire
